// file: src/pseq_core.v
//
// Contract
// [RULE_01] pc steps by one per instruction cycle unless a transfer loads it; here the cycle that executes a table read holds pc
// [RULE_02] only the low pc byte is a software register; here the state register also reads back the whole pc
// [RULE_03] jump, call, interrupt and reset load a target address into pc
// [RULE_04] a met skip discards the prefetched word and runs a dummy cycle
// [RULE_05] pc high part is two bits small variant, three bits large
// [RULE_06] writing pc low byte jumps inside the current 256 word page
// [RULE_07] a pc low byte jump inserts one dummy cycle
// [RULE_08] four level return stack, pc values only, hidden from software
// [RULE_09] call and interrupt acknowledge push pc on the stack
// [RULE_10] both return commands pop the stack into pc
// [RULE_11] reset leaves the stack empty
// [RULE_12] full stack holds interrupt pending until a return frees a level
// [RULE_13] a call on a full stack still executes
// [RULE_14] overflow loses the oldest saved pc
// [RULE_15] alu ops update carry and zero and write the chosen destination; here only add and sub update carry
// [RULE_16] program words are 16 bits, 1k or 2k deep
// [RULE_17] execution starts at address zero after reset
// [RULE_18] table pointer low and high form a full program address
// [RULE_19] table read puts low byte to data register, high byte to tdh
// [RULE_20] present page table read is relative to the current page
// [RULE_21] table reads take two cycles, tdh is read only
// [RULE_22] programmer holds reset low while programming
// [RULE_23] instruction cycle is four phases, pc steps at the first
`include "pseq_defs.vh"

module pseq_core (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // variant strap, high for the 2k part
  input wire size_large,
  // classic wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // program memory
  output reg [10:0] pm_addr_r,
  input wire [15:0] pm_rdata,
  // decoder side
  output reg [1:0] phase_r,
  output reg [15:0] ir_r,
  output reg slot_ok_r,
  output reg cmd_done_r,
  input wire [3:0] cmd_code,
  input wire [10:0] cmd_addr,
  input wire [7:0] cmd_data,
  input wire [7:0] cmd_dst,
  input wire cmd_to_mem,
  input wire cmd_cond,
  // interrupt request logic
  input wire irq_req,
  output reg irq_ack_r,
  // data memory write port
  output reg dw_we_r,
  output reg [7:0] dw_addr_r,
  output reg [7:0] dw_data_r
);

  reg [10:0] pc_r;
  reg [10:0] stk_r [0:3];
  reg [2:0] depth_r;
  reg big_r;
  reg cap_done_r;
  reg tbl_pend_r;
  reg [7:0] tbl_dst_r;
  reg [7:0] tbl_lo_r;
  reg [2:0] tbl_hi_r;
  reg [7:0] tdh_r;
  reg [7:0] acc_r;
  reg c_r;
  reg z_r;
  reg irq_en_r;
  reg irq_pend_r;
  reg ovf_r;
  reg pcl_pend_r;
  reg [7:0] pcl_wdata_r;

  reg [10:0] pc_nxt;
  reg [10:0] tbl_addr;
  reg [10:0] push_val;
  reg flush;
  reg tbl_go;
  reg push;
  reg pop;
  reg alu_go;
  reg [8:0] alu_res;
  reg alu_sets_c;
  reg [31:0] rd_nxt;
  integer i;

  // small part has no pc bit 10
  function [10:0] pcmask;
    input [10:0] v;
    input big;
    begin
      pcmask = big ? v : (v & `PSEQ_SMALL_HI_MASK); // [RULE_05] [RULE_16]
    end
  endfunction

  wire bound = (phase_r == `PSEQ_PH_LAST);
  wire stk_full = (depth_r == `PSEQ_STK_LEVELS);
  wire [1:0] top_idx = (depth_r == `PSEQ_STK_EMPTY) ? 2'h0 : depth_r[1:0] - 2'h1;
  // a full stack blocks the acknowledge; the request stays pending
  wire take_irq = bound & slot_ok_r & irq_pend_r & irq_en_r & ~stk_full; // [RULE_12]
  wire take_pcl = bound & slot_ok_r & ~take_irq & pcl_pend_r;
  wire take_cmd = bound & slot_ok_r & ~take_irq & ~pcl_pend_r;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;

  always @* begin
    pc_nxt = pc_r;
    tbl_addr = pc_r;
    push_val = pc_r;
    flush = 1'b0;
    tbl_go = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    alu_go = 1'b0;
    alu_res = {1'b0, acc_r};
    alu_sets_c = 1'b0;
    if (bound) begin
      pc_nxt = pcmask(pc_r + `PSEQ_PC_ONE, big_r); // [RULE_01] [RULE_23]
      if (take_irq) begin
        pc_nxt = `PSEQ_IRQ_VEC; // [RULE_03]
        flush = 1'b1;
        push = 1'b1; // [RULE_09]
        push_val = pcmask(pc_r - `PSEQ_PC_ONE, big_r);
      end else if (take_pcl) begin
        pc_nxt = pcmask({pc_r[10:8], pcl_wdata_r}, big_r); // [RULE_06]
        flush = 1'b1; // [RULE_07]
      end else if (take_cmd) begin
        case (cmd_code)
          `PSEQ_CMD_JMP: begin
            pc_nxt = pcmask(cmd_addr, big_r); // [RULE_03]
            flush = 1'b1;
          end
          `PSEQ_CMD_CALL: begin
            // a full stack does not stop the call
            pc_nxt = pcmask(cmd_addr, big_r); // [RULE_03] [RULE_13]
            flush = 1'b1;
            push = 1'b1; // [RULE_09]
          end
          `PSEQ_CMD_SUB_RETURN, `PSEQ_CMD_INT_RETURN: begin
            pc_nxt = stk_r[top_idx]; // [RULE_10]
            flush = 1'b1;
            pop = 1'b1;
          end
          `PSEQ_CMD_SKIP: begin
            flush = cmd_cond; // [RULE_04]
          end
          `PSEQ_CMD_TBRD_FULL: begin
            tbl_go = 1'b1;
            pc_nxt = pc_r;
            tbl_addr = pcmask({tbl_hi_r, tbl_lo_r}, big_r); // [RULE_18]
          end
          `PSEQ_CMD_TBRD_PAGE: begin
            tbl_go = 1'b1;
            pc_nxt = pc_r;
            tbl_addr = pcmask({pc_r[10:8], tbl_lo_r}, big_r); // [RULE_20]
          end
          `PSEQ_CMD_TBRD_LAST: begin
            tbl_go = 1'b1;
            pc_nxt = pc_r;
            tbl_addr = pcmask({`PSEQ_LAST_PAGE, tbl_lo_r}, big_r);
          end
          `PSEQ_CMD_ADD: begin
            alu_go = 1'b1;
            alu_sets_c = 1'b1;
            alu_res = {1'b0, acc_r} + {1'b0, cmd_data}; // [RULE_15]
          end
          `PSEQ_CMD_SUB: begin
            alu_go = 1'b1;
            alu_sets_c = 1'b1;
            // carry means no borrow
            alu_res = {1'b0, acc_r} - {1'b0, cmd_data}; // [RULE_15]
            alu_res[8] = ~alu_res[8];
          end
          `PSEQ_CMD_AND: begin
            alu_go = 1'b1;
            alu_res = {1'b0, acc_r & cmd_data};
          end
          `PSEQ_CMD_OR: begin
            alu_go = 1'b1;
            alu_res = {1'b0, acc_r | cmd_data};
          end
          `PSEQ_CMD_XOR: begin
            alu_go = 1'b1;
            alu_res = {1'b0, acc_r ^ cmd_data};
          end
          `PSEQ_CMD_MOV: begin
            alu_go = 1'b1;
            alu_res = {1'b0, cmd_data};
          end
          default: begin
            flush = 1'b0;
          end
        endcase
      end
    end
  end

  always @* begin
    rd_nxt = `PSEQ_RST_WORD;
    case ({wb_adr_i[7:2], 2'b00})
      `PSEQ_REG_PC_LOW: rd_nxt[7:0] = pc_r[7:0]; // [RULE_02]
      `PSEQ_REG_TBL_LO: rd_nxt[7:0] = tbl_lo_r;
      `PSEQ_REG_TBL_HI: rd_nxt[2:0] = tbl_hi_r;
      `PSEQ_REG_TDH: rd_nxt[7:0] = tdh_r;
      `PSEQ_REG_ACC: rd_nxt[7:0] = acc_r;
      `PSEQ_REG_ALU_ST: begin
        rd_nxt[`PSEQ_ST_C] = c_r;
        rd_nxt[`PSEQ_ST_Z] = z_r;
      end
      `PSEQ_REG_CTRL: rd_nxt[`PSEQ_CTRL_IE] = irq_en_r;
      `PSEQ_REG_STATE: begin
        // the stack pointer is kept out of this view
        rd_nxt[10:0] = pc_r; // [RULE_08]
        rd_nxt[`PSEQ_STATE_PEND] = irq_pend_r;
        rd_nxt[`PSEQ_STATE_OVF] = ovf_r;
        rd_nxt[`PSEQ_STATE_BIG] = big_r;
      end
      default: rd_nxt = `PSEQ_RST_WORD;
    endcase
  end

  // wishbone answer one cycle after the strobe
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `PSEQ_RST_WORD;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= rd_nxt;
      end
    end
  end

  // strap caught once after reset release
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      big_r <= 1'b0;
      cap_done_r <= 1'b0;
    end else if (!cap_done_r) begin
      big_r <= size_large;
      cap_done_r <= 1'b1;
    end
  end

  // software registers; hardware updates below take priority, except that a pc low write beats the take_pcl clear
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tbl_lo_r <= `PSEQ_RST_BYTE;
      tbl_hi_r <= 3'h0;
      acc_r <= `PSEQ_RST_BYTE;
      c_r <= 1'b0;
      z_r <= 1'b0;
      irq_en_r <= 1'b0;
      irq_pend_r <= 1'b0;
      ovf_r <= 1'b0;
      pcl_pend_r <= 1'b0;
      pcl_wdata_r <= `PSEQ_RST_BYTE;
    end else begin
      if (wb_wr && wb_sel_i[0]) begin
        case ({wb_adr_i[7:2], 2'b00})
          `PSEQ_REG_TBL_LO: tbl_lo_r <= wb_dat_i[7:0];
          `PSEQ_REG_TBL_HI: tbl_hi_r <= wb_dat_i[2:0];
          `PSEQ_REG_ACC: acc_r <= wb_dat_i[7:0];
          `PSEQ_REG_ALU_ST: begin
            c_r <= wb_dat_i[`PSEQ_ST_C];
            z_r <= wb_dat_i[`PSEQ_ST_Z];
          end
          `PSEQ_REG_CTRL: irq_en_r <= wb_dat_i[`PSEQ_CTRL_IE];
          default: begin
            ovf_r <= ovf_r;
          end
        endcase
      end
      // tdh has no write path
      if (wb_wr && wb_sel_i[2] && ({wb_adr_i[7:2], 2'b00} == `PSEQ_REG_STATE) &&
          wb_dat_i[`PSEQ_STATE_OVF]) begin
        ovf_r <= 1'b0; // [RULE_21]
      end
      if (push && stk_full) begin
        ovf_r <= 1'b1;
      end
      // a late write replaces one still waiting for its slot
      if (wb_wr && wb_sel_i[0] && ({wb_adr_i[7:2], 2'b00} == `PSEQ_REG_PC_LOW)) begin
        pcl_pend_r <= 1'b1; // [RULE_06]
        pcl_wdata_r <= wb_dat_i[7:0];
      end else if (take_pcl) begin
        pcl_pend_r <= 1'b0;
      end
      irq_pend_r <= irq_req | (irq_pend_r & ~take_irq); // [RULE_12]
      if (take_irq) begin
        irq_en_r <= 1'b0;
      end else if (take_cmd && (cmd_code == `PSEQ_CMD_INT_RETURN)) begin
        irq_en_r <= 1'b1;
      end
      if (alu_go) begin
        if (!cmd_to_mem) begin
          acc_r <= alu_res[7:0]; // [RULE_15]
        end
        z_r <= (alu_res[7:0] == `PSEQ_RST_BYTE);
        if (alu_sets_c) begin
          c_r <= alu_res[8];
        end
      end
    end
  end

  // sequencer, stack and table read
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= `PSEQ_PH_FIRST;
      pc_r <= `PSEQ_RST_VEC; // [RULE_17] [RULE_03]
      pm_addr_r <= `PSEQ_RST_VEC;
      ir_r <= 16'h0000;
      slot_ok_r <= 1'b0;
      cmd_done_r <= 1'b0;
      irq_ack_r <= 1'b0;
      depth_r <= `PSEQ_STK_EMPTY; // [RULE_11]
      for (i = 0; i < 4; i = i + 1) begin
        stk_r[i] <= `PSEQ_PC_ZERO;
      end
      tbl_pend_r <= 1'b0;
      tbl_dst_r <= `PSEQ_RST_BYTE;
      tdh_r <= `PSEQ_RST_BYTE;
      dw_we_r <= 1'b0;
      dw_addr_r <= `PSEQ_RST_BYTE;
      dw_data_r <= `PSEQ_RST_BYTE;
    end else begin
      phase_r <= phase_r + 2'h1; // [RULE_23]
      cmd_done_r <= take_cmd;
      irq_ack_r <= take_irq;
      dw_we_r <= 1'b0;
      if (bound) begin
        pc_r <= pc_nxt;
        pm_addr_r <= tbl_go ? tbl_addr : pc_nxt;
        tbl_pend_r <= tbl_go; // [RULE_21]
        if (tbl_go) begin
          tbl_dst_r <= cmd_dst;
        end
        // the table cycle keeps the prefetched word
        if (tbl_pend_r) begin
          tdh_r <= pm_rdata[15:8]; // [RULE_19]
          dw_we_r <= 1'b1;
          dw_addr_r <= tbl_dst_r;
          dw_data_r <= pm_rdata[7:0];
        end else begin
          ir_r <= pm_rdata; // [RULE_16]
        end
        slot_ok_r <= ~flush & ~tbl_go; // [RULE_04] [RULE_07]
        if (alu_go && cmd_to_mem) begin
          dw_we_r <= 1'b1;
          dw_addr_r <= cmd_dst;
          dw_data_r <= alu_res[7:0];
        end
        if (push) begin
          if (stk_full) begin
            // oldest entry drops off the bottom
            for (i = 0; i < 3; i = i + 1) begin
              stk_r[i] <= stk_r[i + 1]; // [RULE_14]
            end
            stk_r[3] <= push_val;
          end else begin
            stk_r[depth_r[1:0]] <= push_val; // [RULE_08]
            depth_r <= depth_r + 3'h1;
          end
        end else if (pop && (depth_r != `PSEQ_STK_EMPTY)) begin
          depth_r <= depth_r - 3'h1; // [RULE_10]
        end
      end
    end
  end

endmodule

// file: src/pseq_defs.vh
`ifndef PSEQ_DEFS_VH
`define PSEQ_DEFS_VH

// program counter and stack
`define PSEQ_PC_W 11
`define PSEQ_PC_ZERO 11'h000
`define PSEQ_PC_ONE 11'h001
`define PSEQ_RST_VEC 11'h000
`define PSEQ_IRQ_VEC 11'h004
`define PSEQ_STK_LEVELS 3'h4
`define PSEQ_STK_EMPTY 3'h0
`define PSEQ_SMALL_HI_MASK 11'h3ff
`define PSEQ_LAST_PAGE 3'h7

// instruction cycle phases t1..t4
`define PSEQ_PH_FIRST 2'h0
`define PSEQ_PH_LAST 2'h3

// commands from the decoder
`define PSEQ_CMD_NOP 4'h0
`define PSEQ_CMD_JMP 4'h1
`define PSEQ_CMD_CALL 4'h2
`define PSEQ_CMD_SUB_RETURN 4'h3
`define PSEQ_CMD_INT_RETURN 4'h4
`define PSEQ_CMD_SKIP 4'h5
`define PSEQ_CMD_TBRD_FULL 4'h6
`define PSEQ_CMD_TBRD_PAGE 4'h7
`define PSEQ_CMD_TBRD_LAST 4'h8
`define PSEQ_CMD_ADD 4'h9
`define PSEQ_CMD_SUB 4'ha
`define PSEQ_CMD_AND 4'hb
`define PSEQ_CMD_OR 4'hc
`define PSEQ_CMD_XOR 4'hd
`define PSEQ_CMD_MOV 4'he

// register byte offsets
`define PSEQ_REG_PC_LOW 8'h00
`define PSEQ_REG_TBL_LO 8'h04
`define PSEQ_REG_TBL_HI 8'h08
`define PSEQ_REG_TDH 8'h0c
`define PSEQ_REG_ACC 8'h10
`define PSEQ_REG_ALU_ST 8'h14
`define PSEQ_REG_CTRL 8'h18
`define PSEQ_REG_STATE 8'h1c

// field positions and reset values
`define PSEQ_ST_C 0
`define PSEQ_ST_Z 1
`define PSEQ_CTRL_IE 0
`define PSEQ_STATE_PEND 16
`define PSEQ_STATE_OVF 17
`define PSEQ_STATE_BIG 18
`define PSEQ_RST_BYTE 8'h00
`define PSEQ_RST_WORD 32'h00000000

`endif

// file: tb/pseq_core_properties.sv
`include "pseq_defs.vh"

module pseq_chk (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // sequencer
  input wire [10:0] pm_addr_r,
  input wire [1:0] phase_r,
  input wire slot_ok_r,
  input wire cmd_done_r,
  input wire [3:0] cmd_code,
  input wire [10:0] cmd_addr,
  input wire cmd_cond,
  input wire irq_ack_r
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  chk_first_fetch: assert property ($rose(rst_b) |-> pm_addr_r == 11'h000 [*4] ##1 pm_addr_r == 11'h001)
    else $error("first fetch not at address zero");
  chk_phase_ring: assert property (phase_r == 2'h0 |=> phase_r == 2'h1 ##1 phase_r == 2'h2 ##1 phase_r == 2'h3)
    else $error("phase sequence broken");
  chk_fetch_hold: assert property (phase_r != 2'h3 |=> $stable(pm_addr_r) && $stable(slot_ok_r))
    else $error("fetch address moved inside a cycle");
  chk_pc_step: assert property (cmd_done_r && $past(cmd_code) == `PSEQ_CMD_NOP
    |-> pm_addr_r == $past(pm_addr_r) + 11'h001)
    else $error("pc did not step by one");
  chk_jump_load: assert property (cmd_done_r && $past(cmd_code) == `PSEQ_CMD_JMP
    |-> pm_addr_r == $past(cmd_addr) && !slot_ok_r)
    else $error("jump target not loaded");
  chk_skip_dummy: assert property (cmd_done_r && $past(cmd_code) == `PSEQ_CMD_SKIP && $past(cmd_cond)
    |-> !slot_ok_r ##4 slot_ok_r)
    else $error("met skip without one dummy cycle");
  chk_table_two: assert property (cmd_done_r && $past(cmd_code) inside {`PSEQ_CMD_TBRD_FULL,
    `PSEQ_CMD_TBRD_PAGE, `PSEQ_CMD_TBRD_LAST} |-> !slot_ok_r [*4] ##1 slot_ok_r)
    else $error("table read not two cycles");
  chk_irq_vector: assert property (irq_ack_r |-> pm_addr_r == `PSEQ_IRQ_VEC && !slot_ok_r)
    else $error("acknowledge without vector fetch");
endmodule

bind pseq_core pseq_chk u_pseq_chk (.ref_clk, .rst_b, .pm_addr_r, .phase_r, .slot_ok_r, .cmd_done_r,
  .cmd_code, .cmd_addr, .cmd_cond, .irq_ack_r);

// file: tb/pseq_pmem.sv
module pseq_pmem (
  // fetch port
  input wire [10:0] pm_addr_r,
  output logic [15:0] pm_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // word follows its address, so any fetch or table read is predictable
  assign pm_rdata = {pm_addr_r[7:0] ^ 8'ha5, 5'h00, pm_addr_r[10:8]};
endmodule

// file: tb/tb.sv
`include "pseq_defs.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] rd;
  logic [15:0] exp_w;
  logic [3:0] cmd_code = `PSEQ_CMD_NOP;
  logic [10:0] cmd_addr = 11'h000;
  logic [7:0] cmd_byte = 8'h00;
  logic cmd_cond = 1'b0;
  logic irq_req = 1'b0;
  logic size_large = 1'b1;
  logic cmd_to_mem = 1'b0;
  wire [15:0] ir;
  wire [31:0] wb_dat_o;
  wire [15:0] pm_rdata;
  wire [10:0] pm_addr_r;
  wire [7:0] dw_addr_r, dw_data_r;
  wire [1:0] phase_r;
  wire wb_ack_o, slot_ok_r, cmd_done_r, irq_ack_r, dw_we_r;
  int mismatches = 0;
  int samples_checked = 0;
  int ticks = 0;
  int n;

  pseq_core u_pseq_core (.ref_clk, .rst_b, .size_large(size_large), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o, .wb_ack_o,
    .pm_addr_r, .pm_rdata, .phase_r, .ir_r(ir), .slot_ok_r, .cmd_done_r, .cmd_code, .cmd_addr,
    .cmd_data(cmd_byte), .cmd_dst(cmd_byte), .cmd_to_mem(cmd_to_mem), .cmd_cond, .irq_req, .irq_ack_r,
    .dw_we_r, .dw_addr_r, .dw_data_r);
  pseq_pmem u_pseq_pmem (.pm_addr_r, .pm_rdata);

  always #5 ref_clk = ~ref_clk;

  function automatic logic [15:0] word_at(input logic [10:0] a);
    return {a[7:0] ^ 8'ha5, 5'h00, a[10:8]};
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    ticks <= ticks + 1;
    if (ticks == 5000) begin
      mismatches++;
      stop_test;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // one classic cycle; the idle edge after it keeps requests apart
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    wb_cyc <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      if (wb_ack_o === 1'b1)
        break;
    end
    // no answer at all counts against the run
    if (k == 20)
      mismatches++;
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    @(posedge ref_clk);
  endtask

  // command is set up during phase 3 of an executing cycle and sampled as it ends
  task automatic ex(input logic [3:0] c, input logic [10:0] a, input logic [7:0] b);
    int k;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      if (phase_r === 2'h2 && slot_ok_r === 1'b1)
        break;
    end
    if (k == 40)
      mismatches++;
    cmd_code <= c;
    cmd_addr <= a;
    cmd_byte <= b;
    @(posedge ref_clk);
    cmd_code <= `PSEQ_CMD_NOP;
    @(posedge ref_clk);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    // reset stands for whole cycles, as a programmer holding the pin would
    rst_b <= 1'b1;
    chk(pm_addr_r, 32'h0);
    // the strap is caught at the first edge after release
    @(posedge ref_clk);
    wb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h00040000);
    wb(1'b0, 8'he0, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    ex(`PSEQ_CMD_JMP, 11'h123, 8'h00);
    chk(pm_addr_r, 32'h123);
    repeat (4) @(posedge ref_clk);
    chk(ir, word_at(11'h123));
    for (int i = 0; i < 5; i++) begin
      ex(`PSEQ_CMD_CALL, {3'h3, i[3:0], 4'h0}, 8'h00);
      chk(pm_addr_r, {3'h3, i[3:0], 4'h0});
    end
    wb(1'b1, 8'h18, 32'h1);
    irq_req <= 1'b1;
    @(posedge ref_clk);
    irq_req <= 1'b0;
    wb(1'b0, 8'h1c, 32'h0);
    chk(rd[17:16], 32'h3);
    ex(`PSEQ_CMD_SUB_RETURN, 11'h000, 8'h00);
    chk(pm_addr_r, 32'h331);
    for (n = 0; n < 40 && irq_ack_r !== 1'b1; n++) @(posedge ref_clk);
    chk(pm_addr_r, `PSEQ_IRQ_VEC);
    ex(`PSEQ_CMD_INT_RETURN, 11'h000, 8'h00);
    for (int i = 2; i >= 0; i--) begin
      ex(`PSEQ_CMD_SUB_RETURN, 11'h000, 8'h00);
      chk(pm_addr_r, {3'h3, i[3:0], 4'h1});
    end
    $display("test stack done");
    wb(1'b1, 8'h00, 32'h5c);
    for (n = 0; n < 40 && pm_addr_r !== 11'h35c; n++) @(posedge ref_clk);
    chk(pm_addr_r, 32'h35c);
    chk(slot_ok_r, 32'h0);
    $display("test page jump done");
    wb(1'b1, 8'h04, 32'h06);
    wb(1'b1, 8'h08, 32'h07);
    for (int i = 0; i < 3; i++) begin
      ex(`PSEQ_CMD_TBRD_FULL + i[3:0], 11'h000, 8'h40 + i[7:0]);
      for (n = 0; n < 20 && dw_we_r !== 1'b1; n++) @(posedge ref_clk);
      exp_w = word_at(i == 1 ? 11'h306 : 11'h706);
      chk({dw_addr_r, dw_data_r}, {8'h40 + i[7:0], exp_w[7:0]});
      wb(1'b0, 8'h0c, 32'h0);
      chk(rd, exp_w[15:8]);
    end
    wb(1'b1, 8'h0c, 32'hff);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, exp_w[15:8]);
    $display("test table done");
    wb(1'b1, 8'h10, 32'hff);
    ex(`PSEQ_CMD_ADD, 11'h000, 8'h01);
    wb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h3);
    ex(`PSEQ_CMD_SUB, 11'h000, 8'h01);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'hff);
    wb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    // result to data memory leaves the accumulator alone
    cmd_to_mem <= 1'b1;
    ex(`PSEQ_CMD_MOV, 11'h000, 8'h55);
    cmd_to_mem <= 1'b0;
    chk({dw_addr_r, dw_data_r}, 32'h5555);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'hff);
    $display("test alu done");
    cmd_cond <= 1'b1;
    ex(`PSEQ_CMD_SKIP, 11'h000, 8'h00);
    cmd_cond <= 1'b0;
    chk(slot_ok_r, 32'h0);
    $display("test skip done");
    // second reset in mid-run, now as the small part
    rst_b <= 1'b0;
    size_large <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    wb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    ex(`PSEQ_CMD_CALL, 11'h7f0, 8'h00);
    chk(pm_addr_r, 32'h3f0);
    $display("test small variant done");
    stop_test;
  end
endmodule
